// ### design/cc_desc_decode.sv
// Descriptor decoder: splits the 96-bit descriptor into fields and forms the
// completer ID. Assumes the descriptor word is stable while it is examined.
`timescale 1ns/1ps
module cc_desc_decode (
    input wire logic [95:0] desc, // Raw descriptor bits.
    input wire logic is_endpoint, // High in endpoint configurations.
    input wire logic ari_enable, // Alternative routing-ID interpretation on.
    input wire logic [7:0] captured_bus, // Bus number captured from config.
    input wire logic [4:0] captured_dev, // Device number captured from config.
    output cc_pkg::cpl_header_type hdr, // Decoded fields.
    output logic status_bad, // Status code outside the three legal codes.
    output logic count_bad // Byte or Dword count out of range.
);
    logic use_desc_id;
    logic [7:0] bus_sel;
    logic [4:0] dev_sel;

    // Root complexes always take descriptor values; endpoints follow the enable bit.
    assign use_desc_id = !is_endpoint || desc[cc_pkg::CIDEN_BIT];
    assign bus_sel = use_desc_id ? desc[cc_pkg::BUS_HI:cc_pkg::BUS_LO] : captured_bus;
    assign dev_sel = use_desc_id ? desc[cc_pkg::FUNC_HI:cc_pkg::DEVNUM_LO] : captured_dev;

    // Field extraction; with ARI the whole byte is function number.
    always_comb begin
        hdr.lower_address = desc[cc_pkg::LADDR_HI:cc_pkg::LADDR_LO];
        hdr.address_type_bits = desc[cc_pkg::ATYPE_HI:cc_pkg::ATYPE_LO];
        hdr.byte_count = desc[cc_pkg::BCNT_HI:cc_pkg::BCNT_LO];
        hdr.locked = desc[cc_pkg::LOCKED_BIT];
        hdr.dword_count = desc[cc_pkg::DWCNT_HI:cc_pkg::DWCNT_LO];
        hdr.status = desc[cc_pkg::STATUS_HI:cc_pkg::STATUS_LO];
        hdr.poisoned = desc[cc_pkg::POISON_BIT];
        hdr.requester_id = desc[cc_pkg::REQID_HI:cc_pkg::REQID_LO];
        hdr.tag = desc[cc_pkg::TAG_HI:cc_pkg::TAG_LO];
        if (ari_enable) begin
            hdr.completer_id = {bus_sel, desc[cc_pkg::FUNC_HI:cc_pkg::FUNC_LO]};
        end else begin
            hdr.completer_id = {bus_sel, dev_sel, desc[cc_pkg::DEVNUM_LO-1:cc_pkg::FUNC_LO]};
        end
        hdr.traffic_class = desc[cc_pkg::TC_HI:cc_pkg::TC_LO];
        hdr.attributes = desc[cc_pkg::ATTR_HI:cc_pkg::ATTR_LO];
        hdr.force_crc = desc[cc_pkg::ECRC_BIT];
    end

    // Sanity checks on codes the sender is bound to keep legal.
    assign status_bad = (hdr.status != cc_pkg::SUCCESS_STATUS) &&
                        (hdr.status != cc_pkg::UNSUPPORTED_STATUS) &&
                        (hdr.status != cc_pkg::ABORT_STATUS);
    assign count_bad = (hdr.byte_count > cc_pkg::BCNT_MAX) ||
                       (hdr.dword_count > cc_pkg::DWCNT_MAX);
endmodule

// ### design/cc_pkg.sv
// Constants, field layout and carrier types for the completion return port.
// Assumes one user clock domain; all users write cc_pkg::name explicitly.
// How it works
// - Each packet opens with a 12-byte descriptor: two beats at 64 bits, else one.
// - Bit 46 poisons the completion; the sender keeps it zero without data errors.
// - Bit 88 picks descriptor bus/device over captured values in endpoints.
// - Bit 95 forces an end-to-end CRC digest even when CRC is disabled.
// - Valid must hold for the whole packet; a drop nullifies the completion.
// - Discontinue during a payload packet is sticky and nullifies the completion.
package cc_pkg;
    localparam int DESC_BITS = 96;
    localparam int LADDR_LO = 0;
    localparam int LADDR_HI = 6;
    localparam int ATYPE_LO = 8;
    localparam int ATYPE_HI = 9;
    localparam int BCNT_LO = 16;
    localparam int BCNT_HI = 28;
    localparam int LOCKED_BIT = 29;
    localparam int DWCNT_LO = 32;
    localparam int DWCNT_HI = 42;
    localparam int STATUS_LO = 43;
    localparam int STATUS_HI = 45;
    localparam int POISON_BIT = 46;
    localparam int REQID_LO = 48;
    localparam int REQID_HI = 63;
    localparam int TAG_LO = 64;
    localparam int TAG_HI = 71;
    localparam int FUNC_LO = 72;
    localparam int FUNC_HI = 79;
    localparam int DEVNUM_LO = 75;
    localparam int BUS_LO = 80;
    localparam int BUS_HI = 87;
    localparam int CIDEN_BIT = 88;
    localparam int TC_LO = 89;
    localparam int TC_HI = 91;
    localparam int ATTR_LO = 92;
    localparam int ATTR_HI = 94;
    localparam int ECRC_BIT = 95;
    localparam logic [2:0] SUCCESS_STATUS = 3'h0;
    localparam logic [2:0] UNSUPPORTED_STATUS = 3'h1;
    localparam logic [2:0] ABORT_STATUS = 3'h4;
    localparam logic [12:0] BCNT_MAX = 13'h1000;
    localparam logic [10:0] DWCNT_MAX = 11'h400;
    localparam int DESC_BEATS_NARROW = 2;
    localparam int NARROW_WIDTH = 64;

    // Decoded descriptor as handed to the packet builder.
    typedef struct packed {
        logic force_crc;
        logic [2:0] attributes;
        logic [2:0] traffic_class;
        logic [15:0] completer_id;
        logic [7:0] tag;
        logic [15:0] requester_id;
        logic poisoned;
        logic [2:0] status;
        logic [10:0] dword_count;
        logic locked;
        logic [12:0] byte_count;
        logic [1:0] address_type_bits;
        logic [6:0] lower_address;
    } cpl_header_type;

    // Per-packet outcome flags.
    typedef struct packed {
        logic nullify;
        logic bad_status;
        logic bad_count;
    } cpl_flags_type;
endpackage

// ### design/completer_completion_port.sv
// Completion return port: takes stream packets of descriptor plus payload and
// emits completion packets with a decoded header. Single clock, no buffering.
`timescale 1ns/1ps
module completer_completion_port #(
    parameter int DATA_WIDTH = 256 // Interface width: 64, 128 or 256.
) (
    input wire logic sys_clk, // User clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic [DATA_WIDTH-1:0] in_data, // Incoming beat data.
    input wire logic in_valid, // Incoming beat valid.
    input wire logic in_last, // Incoming end of packet.
    input wire logic in_discontinue, // Sender flags a payload error.
    output logic in_ready, // Port accepts a beat.
    input wire logic is_endpoint, // Endpoint configuration.
    input wire logic ari_enable, // Alternative routing-ID in use.
    input wire logic [7:0] captured_bus, // Captured bus number.
    input wire logic [4:0] captured_dev, // Captured device number.
    input wire logic crc_enable, // Function has CRC generation enabled.
    output cc_pkg::cpl_header_type out_header, // Header of current packet.
    output logic out_header_valid, // One-cycle pulse when header is decoded.
    output logic [DATA_WIDTH-1:0] out_data, // Payload beat.
    output logic out_data_valid, // Payload beat valid.
    output logic out_last, // Last output beat of the packet.
    input wire logic out_ready, // Downstream accepts output.
    output logic out_append_crc, // Append CRC digest to this completion.
    output logic out_nullify, // Completion must be nullified.
    output logic out_poisoned, // Completion is poisoned.
    output cc_pkg::cpl_flags_type out_flags // Per-packet error flags, sticky per packet.
);
    localparam int DESC_BEATS = (DATA_WIDTH == cc_pkg::NARROW_WIDTH) ?
                                cc_pkg::DESC_BEATS_NARROW : 1;

    typedef enum logic [1:0] {
        IDLE,
        DESC_HI,
        PAYLOAD
    } phase_type;

    typedef struct packed {
        phase_type phase;
        logic [cc_pkg::DESC_BITS-1:0] desc;
        logic hdr_pulse;
        logic [DATA_WIDTH-1:0] data;
        logic data_valid;
        logic last;
        logic nullify;
        logic has_payload;
        cc_pkg::cpl_flags_type flags;
    } state_type;

    state_type st_q;
    state_type st_d;
    cc_pkg::cpl_header_type hdr;
    logic status_bad;
    logic count_bad;
    logic beat;
    logic [cc_pkg::DESC_BITS-1:0] desc_now;

    // Descriptor decode, shared with the header output.
    cc_desc_decode decoder (
        .desc(st_q.desc),
        .is_endpoint(is_endpoint),
        .ari_enable(ari_enable),
        .captured_bus(captured_bus),
        .captured_dev(captured_dev),
        .hdr(hdr),
        .status_bad(status_bad),
        .count_bad(count_bad)
    );

    // The output holds its beat until taken, so ready mirrors downstream space.
    assign in_ready = out_ready || !st_q.data_valid;
    assign beat = in_valid && in_ready;

    // First descriptor chunk comes from the low bits of the first beat.
    // A generate keeps the slice of the other width out of elaboration.
    if (DATA_WIDTH >= cc_pkg::DESC_BITS) begin : g_wide_desc
        assign desc_now = in_data[cc_pkg::DESC_BITS-1:0];
    end else begin : g_narrow_desc
        always_comb begin
            desc_now = st_q.desc;
            desc_now[DATA_WIDTH-1:0] = in_data;
        end
    end

    // Packet sequencer: descriptor beat(s), then payload beats until last.
    always_comb begin
        st_d = st_q;
        st_d.hdr_pulse = 1'b0;
        if (st_q.data_valid && out_ready) begin
            st_d.data_valid = 1'b0;
            st_d.last = 1'b0;
        end
        case (st_q.phase)
            IDLE: begin
                if (beat) begin
                    st_d.desc = desc_now;
                    st_d.nullify = 1'b0;
                    st_d.flags = '0;
                    if (DESC_BEATS == 1) begin
                        st_d.hdr_pulse = 1'b1;
                        st_d.has_payload = (desc_now[cc_pkg::DWCNT_HI:cc_pkg::DWCNT_LO] != 11'h000);
                        // Wide beats may carry Dword-aligned payload behind the descriptor.
                        st_d.data = in_data;
                        st_d.data_valid = st_d.has_payload || in_last;
                        st_d.last = in_last;
                        st_d.nullify = in_discontinue && st_d.has_payload;
                        st_d.phase = in_last ? IDLE : PAYLOAD;
                    end else begin
                        st_d.phase = in_last ? IDLE : DESC_HI;
                        st_d.nullify = in_last;
                        // A cut packet still ends with a flagged beat so downstream closes it.
                        st_d.data = in_data;
                        st_d.data_valid = in_last;
                        st_d.last = in_last;
                    end
                end
            end
            DESC_HI: begin
                if (!in_valid) begin
                    st_d.nullify = 1'b1;
                end
                if (beat) begin
                    st_d.desc[cc_pkg::DESC_BITS-1:DATA_WIDTH % cc_pkg::DESC_BITS] =
                        in_data[cc_pkg::DESC_BITS-(DATA_WIDTH % cc_pkg::DESC_BITS)-1:0];
                    st_d.hdr_pulse = 1'b1;
                    // The Dword count sits in the first beat, already held in the register.
                    st_d.has_payload =
                        (st_q.desc[cc_pkg::DWCNT_HI:cc_pkg::DWCNT_LO] != 11'h000);
                    st_d.data = in_data;
                    st_d.data_valid = st_d.has_payload || in_last;
                    st_d.last = in_last;
                    st_d.nullify = st_d.nullify || (in_discontinue && st_d.has_payload);
                    st_d.phase = in_last ? IDLE : PAYLOAD;
                end
            end
            PAYLOAD: begin
                // A drop of valid mid-packet is a sender error.
                if (!in_valid) begin
                    st_d.nullify = 1'b1;
                end
                if (beat) begin
                    st_d.data = in_data;
                    st_d.data_valid = 1'b1;
                    st_d.last = in_last;
                    // Sticky: cleared only when the next packet starts.
                    if (in_discontinue && st_q.has_payload) begin
                        st_d.nullify = 1'b1;
                    end
                    if (in_last) begin
                        st_d.phase = IDLE;
                    end
                end
            end
            default: begin
                st_d.phase = IDLE;
            end
        endcase
        if (st_q.hdr_pulse) begin
            st_d.flags.bad_status = status_bad;
            st_d.flags.bad_count = count_bad;
        end
        st_d.flags.nullify = st_d.nullify;
    end

    // State register; constants only under reset.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs: data comes from flops, header is decoded from the registered descriptor; CRC forced or enabled.
    assign out_header = hdr;
    assign out_header_valid = st_q.hdr_pulse;
    assign out_data = st_q.data;
    assign out_data_valid = st_q.data_valid;
    assign out_last = st_q.last;
    assign out_append_crc = hdr.force_crc || crc_enable;
    assign out_nullify = st_q.nullify;
    assign out_poisoned = hdr.poisoned;
    assign out_flags = st_q.flags;

    // Discontinue on a payload beat must nullify the packet next cycle.
    sticky_disc_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_q.phase == PAYLOAD && beat && in_discontinue && st_q.has_payload && !in_last)
        |=> st_q.nullify)
        else $error("Discontinue did not nullify the completion.");

    // Nullify stays until the packet ends.
    null_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_q.nullify && st_q.phase != IDLE) |=> st_q.nullify)
        else $error("Nullify dropped inside a packet.");

    // Valid dropping inside the payload nullifies the packet.
    valid_drop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_q.phase == PAYLOAD && !in_valid) |=> st_q.nullify)
        else $error("Valid drop not treated as an error.");

    // No beat is taken without the handshake.
    beat_hs_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_q.phase == PAYLOAD && !(in_valid && in_ready)) |=> $stable(st_q.data))
        else $error("Data changed without a handshake.");

    // Header pulse follows a single-beat descriptor on the next cycle.
    hdr_time_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_q.phase == IDLE && beat && !in_last && DESC_BEATS == 1) |=> st_q.hdr_pulse)
        else $error("Header not decoded after descriptor beat.");

    // Forced CRC always yields a digest.
    crc_force_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q.desc[cc_pkg::ECRC_BIT] |-> out_append_crc)
        else $error("Forced CRC not appended.");

    // Endpoint with enable clear uses captured bus number.
    cid_select_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (is_endpoint && !st_q.desc[cc_pkg::CIDEN_BIT])
        |-> (out_header.completer_id[15:8] == captured_bus))
        else $error("Completer ID not taken from captured values.");

    // Last input beat returns the sequencer to idle.
    last_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (beat && in_last) |=> (st_q.phase == IDLE && st_q.last))
        else $error("End of packet not honoured.");
endmodule

// ### testbench/cc_user_model.sv
// User-side source of completion packets for the completion return port.
// Assumes DATA_WIDTH of 128 or more, so the descriptor fits in the first beat.
`timescale 1ns/1ps
module cc_user_model #(
    parameter int DATA_WIDTH = 256 // Interface width in bits.
) (
    input wire logic sys_clk, // User clock.
    input wire logic in_ready, // Port accepts a beat.
    output logic [DATA_WIDTH-1:0] in_data, // Beat data.
    output logic in_valid, // Beat valid.
    output logic in_last, // End of packet.
    output logic in_discontinue // Payload error flag.
);
    // Lines start quiet so the port sees no packet before reset ends.
    initial begin
        in_data = '0;
        in_valid = 1'b0;
        in_last = 1'b0;
        in_discontinue = 1'b0;
    end

    // Released data shows the inverse of the last beat, so stale data never looks fresh.
    task automatic idle();
        @(negedge sys_clk);
        in_valid <= 1'b0;
        in_last <= 1'b0;
        in_discontinue <= 1'b0;
        in_data <= ~in_data;
    endtask

    // One packet per call; a drop or a discontinue is made only when the bench asks.
    task automatic send_packet(input logic [95:0] desc, input int beats, input int drop_at,
                               input int disc_at);
        logic [DATA_WIDTH-1:0] w;
        for (int i = 0; i < beats; i++) begin
            if (i == drop_at) begin
                @(negedge sys_clk);
                in_valid <= 1'b0;
                in_data <= ~in_data;
            end
            // Every 32-bit lane carries the beat index; beat 0 holds the descriptor in its low 96 bits.
            w = {(DATA_WIDTH / 32){32'hC0DE0000 | 32'(i)}};
            if (i == 0) w[95:0] = desc;
            @(negedge sys_clk);
            in_data <= w;
            in_valid <= 1'b1;
            in_last <= (i == beats - 1);
            in_discontinue <= (i == disc_at);
            @(posedge sys_clk);
            while (in_ready !== 1'b1) @(posedge sys_clk);
        end
    endtask
endmodule

// ### testbench/completer_completion_port_tb.sv
// Self-checking bench for the completion return port at 256 bits.
// Assumes the user model drives the input stream and this module drives the rest.
`timescale 1ns/1ps
module completer_completion_port_tb;
    logic sys_clk, rstn, in_valid, in_last, in_discontinue, in_ready, is_endpoint;
    logic ari_enable, crc_enable, out_header_valid, out_data_valid, out_last, out_ready;
    logic out_append_crc, out_nullify, out_poisoned, stall;
    logic [255:0] in_data, out_data;
    logic [7:0] captured_bus;
    logic [4:0] captured_dev;
    cc_pkg::cpl_header_type out_header;
    cc_pkg::cpl_flags_type out_flags;
    logic [86:0] hq[$];
    logic [86:0] eh;
    logic [2:0] sts[4] = '{cc_pkg::SUCCESS_STATUS, cc_pkg::UNSUPPORTED_STATUS,
                           cc_pkg::ABORT_STATUS, 3'h2};
    int failures = 0, checks = 0, obeats = 0, lasts = 0, cycles = 0, pb = 0;

    completer_completion_port #(.DATA_WIDTH(256)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .in_data(in_data), .in_valid(in_valid), .in_last(in_last),
        .in_discontinue(in_discontinue), .in_ready(in_ready), .is_endpoint(is_endpoint),
        .ari_enable(ari_enable), .captured_bus(captured_bus), .captured_dev(captured_dev),
        .crc_enable(crc_enable), .out_header(out_header), .out_header_valid(out_header_valid),
        .out_data(out_data), .out_data_valid(out_data_valid), .out_last(out_last),
        .out_ready(out_ready), .out_append_crc(out_append_crc), .out_nullify(out_nullify),
        .out_poisoned(out_poisoned), .out_flags(out_flags));
    cc_user_model #(.DATA_WIDTH(256)) user (.sys_clk(sys_clk), .in_ready(in_ready),
        .in_data(in_data), .in_valid(in_valid), .in_last(in_last),
        .in_discontinue(in_discontinue));

    // A 40 ns clock; the timeout ceiling sits far above the planned run.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [95:0] mk(logic [6:0] la, logic [1:0] at, logic [12:0] bc,
        logic lk, logic [10:0] dw, logic [2:0] st, logic [7:0] fn, logic ec, logic po, logic ce);
        return {ec, 3'h3, 3'h5, ce, 8'h5A, fn, 8'h3C, 16'h1A2B, 1'b0, po, st, dw, 2'h0, lk, bc,
                6'h0, at, 1'b0, la};
    endfunction

    // Completer ID source follows the endpoint and enable bits; crc and poison ride above.
    function automatic logic [86:0] expect_of(logic [95:0] d);
        cc_pkg::cpl_header_type h;
        logic [7:0] bus;
        logic [4:0] dev;
        bus = (is_endpoint && !d[88]) ? captured_bus : d[87:80];
        dev = (is_endpoint && !d[88]) ? captured_dev : d[79:75];
        h = {d[95:89], 16'h0, d[71:48], d[46:32], d[29:16], d[9:8], d[6:0]};
        h.completer_id = ari_enable ? {bus, d[79:72]} : {bus, dev, d[74:72]};
        return {d[95] | crc_enable, d[46], h};
    endfunction

    // Total bytes of a read from its leading and trailing byte enables.
    function automatic logic [12:0] total_bytes(logic [3:0] lead, logic [3:0] trail,
        logic [10:0] dw);
        logic [12:0] gap;
        gap = lead[0] ? 13'h0 : lead[1] ? 13'h1 : lead[2] ? 13'h2 : 13'h3;
        gap += trail[3] ? 13'h0 : trail[2] ? 13'h1 : trail[1] ? 13'h2 : 13'h3;
        if (trail != 4'h0) return {dw, 2'b00} - gap;
        casez (lead)
            4'b1??1: return 13'h4;
            4'b01?1, 4'b1?10: return 13'h3;
            4'b0011, 4'b0110, 4'b1100: return 13'h2;
            default: return 13'h1;
        endcase
    endfunction

    // Headers are matched in order against what was sent; output beats are counted.
    always @(posedge sys_clk) begin
        if (rstn === 1'b1 && out_header_valid === 1'b1) begin
            eh = (hq.size() > 0) ? hq.pop_front() : '1;
            check("header", out_header, eh[84:0]);
            check("poisoned", out_poisoned, eh[85]);
            check("append crc", out_append_crc, eh[86]);
        end
        if (rstn === 1'b1 && out_data_valid === 1'b1 && out_ready === 1'b1) begin
            check("out data", out_data[255:224], 32'hC0DE0000 | 32'(pb));
            pb = (out_last === 1'b1) ? 0 : pb + 1;
            obeats++;
            if (out_last === 1'b1) lasts++;
        end
    end
    // Downstream stalls every other pair of cycles when asked to.
    always @(negedge sys_clk) out_ready <= stall ? cycles[1] : 1'b1;

    task automatic send(logic [95:0] d, int drop_at, int disc_at);
        hq.push_back(expect_of(d));
        user.send_packet(d, (int'(d[42:32]) + 10) / 8, drop_at, disc_at);
    endtask

    task automatic settle(int eb, int el, logic [2:0] fl);
        user.idle();
        for (int i = 0; i < 60 && obeats < eb; i++) @(negedge sys_clk);
        repeat (3) @(negedge sys_clk);
        if (eb >= 0) check("out beats", obeats, eb);
        if (eb >= 0) check("last flags", lasts, el);
        check("nullify", out_nullify, fl[2]);
        check("flags", out_flags, fl);
        obeats = 0;
        lasts = 0;
    endtask

    task automatic cfg(logic ep, logic ar, logic ce);
        @(negedge sys_clk);
        is_endpoint = ep;
        ari_enable = ar;
        crc_enable = ce;
    endtask

    initial begin
        rstn = 1'b0;
        stall = 1'b0;
        is_endpoint = 1'b1;
        ari_enable = 1'b0;
        crc_enable = 1'b0;
        captured_bus = 8'h12;
        captured_dev = 5'h0B;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        check("ready after reset", in_ready, 1'b1);
        send(mk(7'h25, 2'h2, total_bytes(4'hE, 4'hF, 11'h014), 0, 11'h014, 3'h0, 8'h03, 0, 0,
                0), -1, -1);
        settle(3, 1, 3'b000);
        stall = 1'b1;
        send(mk(7'h04, 2'h1, 13'h050, 0, 11'h005, 3'h0, 8'h02, 0, 0, 0), -1, -1);
        send(mk(7'h18, 2'h1, 13'h03C, 0, 11'h014, 3'h0, 8'h02, 0, 0, 0), -1, -1);
        settle(4, 2, 3'b000);
        stall = 1'b0;
        send(mk(7'h00, 2'h0, 13'h004, 0, 11'h000, 3'h0, 8'h01, 0, 0, 0), -1, -1);
        settle(1, 1, 3'b000);
        send(mk(7'h00, 2'h0, 13'h001, 1, 11'h001, 3'h0, 8'h01, 0, 0, 0), -1, -1);
        settle(1, 1, 3'b000);
        foreach (sts[i]) begin
            send(mk(7'h00, 2'h0, 13'h004, 0, 11'h000, sts[i], 8'h01, 0, 0, 0), -1, -1);
            settle(1, 1, {1'b0, sts[i] == 3'h2, 1'b0});
        end
        send(mk(7'h00, 2'h0, 13'h1001, 0, 11'h000, 3'h0, 8'h01, 0, 0, 0), -1, -1);
        settle(1, 1, 3'b001);
        cfg(1, 1, 0);
        send(mk(7'h08, 2'h0, 13'h004, 0, 11'h001, 3'h0, 8'hA6, 1, 1, 1), -1, -1);
        settle(1, 1, 3'b000);
        cfg(0, 0, 1);
        send(mk(7'h08, 2'h0, 13'h004, 0, 11'h001, 3'h0, 8'hB5, 0, 0, 0), -1, -1);
        settle(1, 1, 3'b000);
        cfg(1, 0, 0);
        send(mk(7'h00, 2'h0, 13'h050, 0, 11'h014, 3'h0, 8'h01, 0, 0, 0), -1, 1);
        settle(-1, 0, 3'b100);
        send(mk(7'h00, 2'h0, 13'h004, 0, 11'h001, 3'h0, 8'h01, 0, 0, 0), -1, -1);
        settle(1, 1, 3'b000);
        send(mk(7'h00, 2'h0, 13'h050, 0, 11'h014, 3'h0, 8'h01, 0, 0, 0), 2, -1);
        settle(-1, 0, 3'b100);
        finish_test();
    end
endmodule
